// ==== inc/spfc_pkg.sv ====
// spfc_pkg: constants and carrier types for the switch port flow control registers
// assumes a simple word-wide register access port on the core clock
// Contract
// - port 2 bit 6 enables half-duplex backpressure, read/write
// - port 2 bit 5 read-only: actual duplex, 0 full, 1 half
// - port 2 bit 4 read-only: receive flow control currently active
// - port 2 bit 3 read-only: transmit flow control currently active
// - port 2 bit 2 enables pause detection when manual or autoneg off
// - port 2 bit 1 enables pause generation when manual or autoneg off
// - port 2 manual 0: autoneg result if autoneg on, else enable bits
// - port 2 manual 1: enable bits apply whenever full duplex
// - port 1 bit 1 enables pause generation when manual or autoneg off
// - port 1 manual 0: autoneg result if autoneg on, else enable bits
// - port 1 manual 1: enable bits apply while full duplex
// - writable fields reset from straps, reloaded when loader rewrites straps
// - status bits derive from link state and the writable fields; duplex from link state only
// - registers report the flow control actually in force
// - phy advertisement flow control bits are never changed here
// - port 2 bits 31 to 7 reserved, read as zero
// - port 1 bit 2 enables pause detection when manual or autoneg off
// - port 1 bit 6 enables half-duplex backpressure
// - port 1 bits 5,4,3 report duplex, rx and tx flow control active
package spfc_pkg;
    localparam logic [11:0] SPFC_PORT1_OFFSET = 12'h1a0;
    localparam logic [11:0] SPFC_PORT2_OFFSET = 12'h1a4;
    localparam int          SPFC_BIT_BACKPRESSURE = 6;
    localparam int          SPFC_BIT_DUPLEX       = 5;
    localparam int          SPFC_BIT_RX_ACTIVE    = 4;
    localparam int          SPFC_BIT_TX_ACTIVE    = 3;
    localparam int          SPFC_BIT_RX_ENABLE    = 2;
    localparam int          SPFC_BIT_TX_ENABLE    = 1;
    localparam int          SPFC_BIT_MANUAL       = 0;
    localparam logic [31:0] SPFC_READ_ZERO        = 32'h0000_0000;

    // per-port configuration straps, possibly rewritten by the loader
    typedef struct packed {
        logic backpressure;
        logic pause;
        logic manual_select;
    } spfc_strap_type;

    // per-port writable fields
    typedef struct packed {
        logic backpressure_enable;
        logic rx_pause_enable;
        logic tx_pause_enable;
        logic manual_select;
    } spfc_cfg_type;

    // link state from the phy side
    typedef struct packed {
        logic half_duplex;
        logic autoneg_on;
        logic an_rx_pause;
        logic an_tx_pause;
    } spfc_link_type;

    // resolved flow control in force
    typedef struct packed {
        logic half_duplex;
        logic rx_pause_active;
        logic tx_pause_active;
        logic backpressure;
    } spfc_res_type;

    typedef struct packed {
        spfc_cfg_type cfg;
        spfc_res_type res;
    } spfc_port_state_type;
endpackage

// ==== logic/spfc_port.sv ====
// spfc_port: one port's writable fields and flow control resolution
// assumes straps and link state are already synchronous to the core clock
`timescale 1ns/1ps
module spfc_port (
    // clock and reset
    input  wire logic                    i_core_clk,
    input  wire logic                    i_rst_n,
    // strap load
    input  wire logic                    i_strap_load,
    input  wire spfc_pkg::spfc_strap_type i_strap,
    // register write
    input  wire logic                    i_wr,
    input  wire logic [31:0]             i_wdata,
    // link state
    input  wire spfc_pkg::spfc_link_type i_link,
    // outputs
    output spfc_pkg::spfc_cfg_type       o_cfg,
    output spfc_pkg::spfc_res_type       o_res
);
    spfc_pkg::spfc_port_state_type state;
    spfc_pkg::spfc_port_state_type next_state;
    logic                          use_enables;

    always_comb begin
        next_state = state;
        if (i_strap_load) begin
            next_state.cfg.backpressure_enable = i_strap.backpressure;
            next_state.cfg.rx_pause_enable     = i_strap.pause;
            next_state.cfg.tx_pause_enable     = i_strap.pause;
            next_state.cfg.manual_select       = i_strap.manual_select;
        end else if (i_wr) begin
            // only writable fields are taken, status bits stay derived
            next_state.cfg.backpressure_enable = i_wdata[spfc_pkg::SPFC_BIT_BACKPRESSURE];
            next_state.cfg.rx_pause_enable     = i_wdata[spfc_pkg::SPFC_BIT_RX_ENABLE];
            next_state.cfg.tx_pause_enable     = i_wdata[spfc_pkg::SPFC_BIT_TX_ENABLE];
            next_state.cfg.manual_select       = i_wdata[spfc_pkg::SPFC_BIT_MANUAL];
        end
        // manual or autoneg off: enable bits; else autoneg result
        use_enables = next_state.cfg.manual_select | ~i_link.autoneg_on;
        next_state.res.half_duplex  = i_link.half_duplex;
        next_state.res.backpressure = next_state.cfg.backpressure_enable & i_link.half_duplex;
        if (i_link.half_duplex) begin
            next_state.res.rx_pause_active = 1'b0;
            next_state.res.tx_pause_active = 1'b0;
        end else if (use_enables) begin
            next_state.res.rx_pause_active = next_state.cfg.rx_pause_enable;
            next_state.res.tx_pause_active = next_state.cfg.tx_pause_enable;
        end else begin
            next_state.res.rx_pause_active = i_link.an_rx_pause;
            next_state.res.tx_pause_active = i_link.an_tx_pause;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign o_cfg = state.cfg;
    assign o_res = state.res;
endmodule // spfc_port

// ==== logic/spfc_regs.sv ====
// spfc_regs: two-port flow control register bank for the switch fabric
// assumes a word register port on the core clock; straps are pins
`timescale 1ns/1ps
module spfc_regs (
    // clock and reset
    input  wire logic                     i_core_clk,
    input  wire logic                     i_resetn,
    // register access
    input  wire logic                     i_reg_wr,
    input  wire logic                     i_reg_rd,
    input  wire logic [11:0]              i_reg_addr,
    input  wire logic [31:0]              i_reg_wdata,
    output logic [31:0]                   o_reg_rdata,
    output logic                          o_reg_rvalid,
    // straps, pins, and loader rewrite pulse
    input  wire spfc_pkg::spfc_strap_type i_port1_strap,
    input  wire spfc_pkg::spfc_strap_type i_port2_strap,
    input  wire logic                     i_loader_rewrite,
    // link state from the phys
    input  wire spfc_pkg::spfc_link_type  i_port1_link,
    input  wire spfc_pkg::spfc_link_type  i_port2_link,
    // resolved flow control to the mac
    output spfc_pkg::spfc_res_type        o_port1_fc,
    output spfc_pkg::spfc_res_type        o_port2_fc
);
    // ----------------------------------------
    // reset release and input synchronisers
    // ----------------------------------------
    typedef struct packed {
        logic [1:0]               rst_sync;
        logic                     rst_done;
        spfc_pkg::spfc_strap_type s1_a;
        spfc_pkg::spfc_strap_type s1_b;
        spfc_pkg::spfc_strap_type s2_a;
        spfc_pkg::spfc_strap_type s2_b;
        logic                     ld_a;
        logic                     ld_b;
        logic                     ld_c;
        spfc_pkg::spfc_link_type  l1_a;
        spfc_pkg::spfc_link_type  l1_b;
        spfc_pkg::spfc_link_type  l2_a;
        spfc_pkg::spfc_link_type  l2_b;
        logic [31:0]              rdata;
        logic                     rvalid;
    } spfc_top_state_type;

    spfc_top_state_type     state;
    spfc_top_state_type     next_state;
    logic                   rst_n;
    logic                   load1;
    logic                   load2;
    logic                   wr1;
    logic                   wr2;
    spfc_pkg::spfc_cfg_type cfg1;
    spfc_pkg::spfc_cfg_type cfg2;
    spfc_pkg::spfc_res_type res1;
    spfc_pkg::spfc_res_type res2;

    // reset synchroniser kept apart so reset reaches only constants
    logic [1:0] rst_pipe;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_pipe <= 2'h0;
        end else begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe[1];

    // ----------------------------------------
    // straps load once after release, then on each loader rewrite
    // ----------------------------------------
    // first load waits until the strap synchronisers hold pin values, not reset zeros
    assign load1 = (state.rst_sync[1] & ~state.rst_done) | (state.ld_b & ~state.ld_c);
    assign load2 = load1;
    assign wr1   = i_reg_wr & (i_reg_addr == spfc_pkg::SPFC_PORT1_OFFSET);
    assign wr2   = i_reg_wr & (i_reg_addr == spfc_pkg::SPFC_PORT2_OFFSET);

    always_comb begin
        next_state          = state;
        next_state.rst_sync = {state.rst_sync[0], 1'b1};
        next_state.rst_done = state.rst_sync[1];
        next_state.s1_a     = i_port1_strap;
        next_state.s1_b     = state.s1_a;
        next_state.s2_a     = i_port2_strap;
        next_state.s2_b     = state.s2_a;
        next_state.ld_a     = i_loader_rewrite;
        next_state.ld_b     = state.ld_a;
        next_state.ld_c     = state.ld_b;
        next_state.l1_a     = i_port1_link;
        next_state.l1_b     = state.l1_a;
        next_state.l2_a     = i_port2_link;
        next_state.l2_b     = state.l2_a;
        next_state.rvalid   = i_reg_rd;
        next_state.rdata    = spfc_pkg::SPFC_READ_ZERO;
        if (i_reg_rd) begin
            if (i_reg_addr == spfc_pkg::SPFC_PORT1_OFFSET) begin
                next_state.rdata[spfc_pkg::SPFC_BIT_BACKPRESSURE] = cfg1.backpressure_enable;
                next_state.rdata[spfc_pkg::SPFC_BIT_DUPLEX]       = res1.half_duplex;
                next_state.rdata[spfc_pkg::SPFC_BIT_RX_ACTIVE]    = res1.rx_pause_active;
                next_state.rdata[spfc_pkg::SPFC_BIT_TX_ACTIVE]    = res1.tx_pause_active;
                next_state.rdata[spfc_pkg::SPFC_BIT_RX_ENABLE]    = cfg1.rx_pause_enable;
                next_state.rdata[spfc_pkg::SPFC_BIT_TX_ENABLE]    = cfg1.tx_pause_enable;
                next_state.rdata[spfc_pkg::SPFC_BIT_MANUAL]       = cfg1.manual_select;
            end else if (i_reg_addr == spfc_pkg::SPFC_PORT2_OFFSET) begin
                next_state.rdata[spfc_pkg::SPFC_BIT_BACKPRESSURE] = cfg2.backpressure_enable;
                next_state.rdata[spfc_pkg::SPFC_BIT_DUPLEX]       = res2.half_duplex;
                next_state.rdata[spfc_pkg::SPFC_BIT_RX_ACTIVE]    = res2.rx_pause_active;
                next_state.rdata[spfc_pkg::SPFC_BIT_TX_ACTIVE]    = res2.tx_pause_active;
                next_state.rdata[spfc_pkg::SPFC_BIT_RX_ENABLE]    = cfg2.rx_pause_enable;
                next_state.rdata[spfc_pkg::SPFC_BIT_TX_ENABLE]    = cfg2.tx_pause_enable;
                next_state.rdata[spfc_pkg::SPFC_BIT_MANUAL]       = cfg2.manual_select;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------
    // per-port fields; phy advertisement has no path from here
    // ----------------------------------------
    spfc_port u_port1 (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (rst_n),
        .i_strap_load (load1),
        .i_strap      (state.s1_b),
        .i_wr         (wr1),
        .i_wdata      (i_reg_wdata),
        .i_link       (state.l1_b),
        .o_cfg        (cfg1),
        .o_res        (res1)
    );

    spfc_port u_port2 (
        .i_core_clk   (i_core_clk),
        .i_rst_n      (rst_n),
        .i_strap_load (load2),
        .i_strap      (state.s2_b),
        .i_wr         (wr2),
        .i_wdata      (i_reg_wdata),
        .i_link       (state.l2_b),
        .o_cfg        (cfg2),
        .o_res        (res2)
    );

    assign o_reg_rdata  = state.rdata;
    assign o_reg_rvalid = state.rvalid;
    assign o_port1_fc   = res1;
    assign o_port2_fc   = res2;
endmodule // spfc_regs

// ==== tb/spfc_regs_properties.sv ====
// spfc_regs_properties: port-level checks of the flow control register bank
// assumes it is bound onto spfc_regs and sees only its ports
`timescale 1ns/1ps
module spfc_regs_properties (
    input wire logic                   i_core_clk,
    input wire logic                   i_resetn,
    input wire logic                   i_reg_rd,
    input wire logic [11:0]            i_reg_addr,
    input wire logic [31:0]            o_reg_rdata,
    input wire logic                   o_reg_rvalid,
    input wire spfc_pkg::spfc_res_type o_port1_fc,
    input wire spfc_pkg::spfc_res_type o_port2_fc
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_resetn);
    // ----------------
    // read decode
    // ----------------
    logic rd1;
    logic rd2;
    assign rd1 = i_reg_rd && (i_reg_addr == spfc_pkg::SPFC_PORT1_OFFSET);
    assign rd2 = i_reg_rd && (i_reg_addr == spfc_pkg::SPFC_PORT2_OFFSET);
    // ----------------
    // assertions
    // ----------------
    a_rvalid_follows: assert property (i_reg_rd |=> o_reg_rvalid)
        else $error("read not answered");
    a_rvalid_only_read: assert property (!i_reg_rd |=> !o_reg_rvalid)
        else $error("answer without read");
    a_reserved_zero: assert property (o_reg_rvalid |-> o_reg_rdata[31:7] == 25'h0)
        else $error("reserved bits not zero");
    a_unmapped_zero: assert property (i_reg_rd && !rd1 && !rd2 |=>
        o_reg_rdata == spfc_pkg::SPFC_READ_ZERO) else $error("unmapped read not zero");
    a_status_two: assert property (rd2 ##1 $stable(o_port2_fc) |->
        o_reg_rdata[5:3] == o_port2_fc[3:1]) else $error("port 2 status mismatch");
    a_status_one: assert property (rd1 ##1 $stable(o_port1_fc) |->
        o_reg_rdata[5:3] == o_port1_fc[3:1]) else $error("port 1 status mismatch");
    a_bp_two: assert property (rd2 ##1 $stable(o_port2_fc) |->
        o_port2_fc[0] == (o_reg_rdata[6] & o_reg_rdata[5])) else $error("port 2 bp wrong");
    a_bp_one: assert property (rd1 ##1 $stable(o_port1_fc) |->
        o_port1_fc[0] == (o_reg_rdata[6] & o_reg_rdata[5])) else $error("port 1 bp wrong");
    a_manual_two: assert property (rd2 ##1 ($stable(o_port2_fc) &&
        o_reg_rdata[0] && !o_reg_rdata[5]) |-> o_port2_fc[2:1] == o_reg_rdata[2:1])
        else $error("port 2 manual pause wrong");
    a_manual_one: assert property (rd1 ##1 ($stable(o_port1_fc) &&
        o_reg_rdata[0] && !o_reg_rdata[5]) |-> o_port1_fc[2:1] == o_reg_rdata[2:1])
        else $error("port 1 manual pause wrong");
    c_half_read: cover property (rd2 ##1 o_reg_rdata[5]);
    c_rx_active: cover property (o_port1_fc.rx_pause_active);
    c_backpressure: cover property (o_port2_fc.backpressure);
endmodule // spfc_regs_properties

bind spfc_regs spfc_regs_properties u_props (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
    .o_port1_fc(o_port1_fc), .o_port2_fc(o_port2_fc));

// ==== tb/spfc_host.sv ====
// spfc_host: host side model issuing single word register accesses
// assumes the caller waits out reset release before the first access
`timescale 1ns/1ps
module spfc_host (
    // clock
    input  wire logic  i_core_clk,
    // register access
    output logic       o_wr,
    output logic       o_rd,
    output logic [11:0] o_addr,
    output logic [31:0] o_wdata
);
    initial begin
        {o_wr, o_rd} = 2'b00;
        {o_addr, o_wdata} = 44'h0;
    end
    // one strobe cycle; released lines show the inverse so stale values never match
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        #1;
        {o_wr, o_rd, o_addr, o_wdata} = {w, !w, a, d};
        @(posedge i_core_clk);
        #1;
        {o_wr, o_rd, o_addr, o_wdata} = {2'b00, ~a, ~d};
    endtask
endmodule // spfc_host

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the flow control register bank
// assumes spfc_host drives the register port and a queue holds expected reads
`timescale 1ns/1ps
module tb_top;
    logic                     i_core_clk;
    logic                     i_resetn;
    logic                     wr, rd, rvalid, rew;
    logic [11:0]              addr;
    logic [31:0]              wdata, rdata, wd;
    spfc_pkg::spfc_strap_type s1, s2;
    spfc_pkg::spfc_link_type  l1, l2;
    spfc_pkg::spfc_res_type   f1, f2;
    logic [3:0]               c1, c2;
    logic [15:0]              rnd;
    logic [31:0]              expq[$];
    int                       fail_count = 0;
    int                       n_compared = 0;

    spfc_host u_host (.i_core_clk(i_core_clk), .o_wr(wr), .o_rd(rd), .o_addr(addr),
        .o_wdata(wdata));
    spfc_regs u_dut (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_reg_wr(wr),
        .i_reg_rd(rd), .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata),
        .o_reg_rvalid(rvalid), .i_port1_strap(s1), .i_port2_strap(s2),
        .i_loader_rewrite(rew), .i_port1_link(l1), .i_port2_link(l2),
        .o_port1_fc(f1), .o_port2_fc(f2));
    // ----------------
    // reference model
    // ----------------
    function automatic logic [15:0] lfsr(logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [3:0] strap_cfg(spfc_pkg::spfc_strap_type s);
        return {s.backpressure, s.pause, s.pause, s.manual_select};
    endfunction
    function automatic logic [31:0] exp_reg(logic [3:0] c, spfc_pkg::spfc_link_type l);
        logic rx;
        logic tx;
        rx = !l.half_duplex && ((c[0] || !l.autoneg_on) ? c[2] : l.an_rx_pause);
        tx = !l.half_duplex && ((c[0] || !l.autoneg_on) ? c[1] : l.an_tx_pause);
        return {25'h0, c[3], l.half_duplex, rx, tx, c[2:0]};
    endfunction
    function automatic logic [3:0] exp_fc(logic [3:0] c, spfc_pkg::spfc_link_type l);
        logic [31:0] r;
        r = exp_reg(c, l);
        return {r[5:3], r[6] & r[5]};
    endfunction
    // ----------------
    // checking
    // ----------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic rd_exp(input logic [11:0] a, input logic [31:0] e);
        expq.push_back(e);
        u_host.access(1'b0, a, 32'h0);
    endtask
    task automatic settle_check();
        repeat (5) @(posedge i_core_clk);
        #1;
        check({28'h0, f1}, {28'h0, exp_fc(c1, l1)});
        check({28'h0, f2}, {28'h0, exp_fc(c2, l2)});
        rd_exp(spfc_pkg::SPFC_PORT1_OFFSET, exp_reg(c1, l1));
        rd_exp(spfc_pkg::SPFC_PORT2_OFFSET, exp_reg(c2, l2));
    endtask
    always @(negedge i_core_clk) begin
        if (rvalid === 1'b1 && expq.size() > 0) begin
            check(rdata, expq.pop_front());
        end else if (rvalid === 1'b1) begin
            check(rdata, ~rdata);
        end
    end
    // ----------------
    // stimulus
    // ----------------
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        repeat (50000) @(posedge i_core_clk);
        fail_count++;
        end_of_test();
    end
    initial begin
        {i_resetn, rew, rnd} = {2'b00, 16'ha2bd};
        {s1, s2, l1, l2} = 14'b101_010_0110_0101;
        repeat (16) @(posedge i_core_clk);
        #1;
        i_resetn = 1'b1;
        repeat (6) @(posedge i_core_clk);
        {c1, c2} = {strap_cfg(s1), strap_cfg(s2)};
        settle_check();
        rd_exp(12'h1a8, 32'h0);
        for (int i = 0; i < 24; i++) begin
            rnd = lfsr(rnd);
            wd = {rnd, lfsr(rnd)};
            rnd = lfsr(lfsr(rnd));
            {l1, l2} = rnd[7:0];
            u_host.access(1'b1, rnd[8] ? 12'h1a4 : 12'h1a0, wd);
            u_host.access(1'b1, 12'h1ac, ~wd);
            if (rnd[8]) c2 = {wd[6], wd[2:0]};
            else c1 = {wd[6], wd[2:0]};
            settle_check();
        end
        {s1, s2} = ~{s1, s2};
        repeat (4) @(posedge i_core_clk);
        #1;
        rew = 1'b1;
        {c1, c2} = {strap_cfg(s1), strap_cfg(s2)};
        settle_check();
        rew = 1'b0;
        repeat (4) @(posedge i_core_clk);
        if (expq.size() != 0) fail_count++;
        end_of_test();
    end
endmodule // tb_top
